// [src/mbpr_pkg.sv]
// mbpr_pkg: offsets, field layouts, reset values and carrier types for the
// microphone bias and preamplifier routing register bank.
// assumes an 8-bit register port with one-cycle strobes.
package mbpr_pkg;

  // ==========================================================================
  // widths and offsets
  localparam int MBPR_AW = 8;
  localparam int MBPR_DW = 8;
  localparam logic [7:0] RSVD_A_FIRST = 8'h1A;
  localparam logic [7:0] RSVD_A_LAST = 8'h32;
  localparam logic [7:0] MIC_BIAS_CONFIG_OFS = 8'h33;
  localparam logic [7:0] LEFT_PREAMP_POS_OFS = 8'h34;
  localparam logic [7:0] RSVD_B_OFS = 8'h35;
  localparam logic [7:0] LEFT_PREAMP_NEG_OFS = 8'h36;
  localparam logic [7:0] RIGHT_PREAMP_POS_OFS = 8'h37;
  localparam logic [7:0] RSVD_C_OFS = 8'h38;

  // ==========================================================================
  // bias register fields
  localparam int BIAS_PWR_BIT = 6;
  localparam int BIAS_LVL_HI = 5;
  localparam int BIAS_LVL_LO = 4;
  localparam int BIAS_SRC_BIT = 3;
  localparam logic [7:0] BIAS_WR_MASK = 8'h78;

  // ==========================================================================
  // reset values and field codes
  localparam logic [7:0] RSVD_RESET = 8'h00;
  localparam logic [7:0] BIAS_RESET = 8'h00;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [1:0] ROUTE_OPEN = 2'h0;
  localparam logic [1:0] ROUTE_10K = 2'h1;
  localparam logic [1:0] ROUTE_20K = 2'h2;
  localparam logic [1:0] ROUTE_40K = 2'h3;
  localparam logic [1:0] BIAS_TO_SUPPLY = 2'h3;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mbpr_bus_s;

  typedef struct packed {
    logic power_up;
    logic [1:0] level;
    logic from_regulator;
    logic direct_to_supply;
  } mbpr_bias_s;

  // one routing field decoded to its switch enables
  typedef struct packed {
    logic sw_10k;
    logic sw_20k;
    logic sw_40k;
  } mbpr_sw_s;

  typedef struct packed {
    mbpr_sw_s input_one_left;
    mbpr_sw_s input_two_left;
    mbpr_sw_s input_three_left;
    mbpr_sw_s input_one_right;
  } mbpr_lpos_s;

  typedef struct packed {
    mbpr_sw_s left_first_common_tap;
    mbpr_sw_s input_two_right;
    mbpr_sw_s input_three_right;
    mbpr_sw_s left_second_common_tap;
  } mbpr_lneg_s;

  typedef struct packed {
    mbpr_sw_s input_one_right;
    mbpr_sw_s input_two_right;
    mbpr_sw_s input_three_right;
    mbpr_sw_s input_two_left;
  } mbpr_rpos_s;

endpackage

// [src/mbpr_route_dec.sv]
// mbpr_route_dec: turns one 8-bit routing register into four groups of
// resistor switch enables, one group per two-bit field.
// assumes the register value is already stored in flip-flops.
`timescale 1ns/1ps
module mbpr_route_dec #(
  parameter int FIELDS = 4
) (
  // stored register value
  input wire logic [2*FIELDS-1:0] route,
  // switch enables, field 0 is the lowest pair of bits
  output logic [3*FIELDS-1:0] sw
);
  import mbpr_pkg::*;

  // ==========================================================================
  // per-field decode
  // one-hot enables so at most one resistor leg closes per source
  genvar g;
  generate
    for (g = 0; g < FIELDS; g++) begin : g_fld
      wire logic [1:0] code = route[2*g+1:2*g];
      assign sw[3*g+2] = (code == ROUTE_10K);
      assign sw[3*g+1] = (code == ROUTE_20K);
      assign sw[3*g] = (code == ROUTE_40K);
    end
  endgenerate

endmodule

// [src/mbpr_regs.sv]
// mbpr_regs: register bank for microphone bias control and preamplifier
// input routing, with static control outputs toward the analog network.
// assumes a synchronous 8-bit register port, reads answered next cycle.
//
// How it works
// - offsets 26 to 50 are reserved bytes that always read zero.
// - bias register bit 6 powers the bias generator up when one.
// - bias bits 5:4 pick one of three levels, code 11 ties to supply.
// - bias bit 3 picks the regulator input supply, zero the analog one.
// - bias bits 7 and 2:0 ignore writes and read zero.
// - every routing field: 00 open, 01 10K, 10 20K, 11 40K.
// - offset 52 routes four inputs to the left positive terminal.
// - offset 53 is a reserved byte that reads zero.
// - offset 54 routes taps and right inputs to the left negative side.
// - offset 55 routes four inputs to the right positive terminal.
// - offset 56 is a reserved byte that reads zero.
// - all routing fields are read/write and reset to open.
// - the bias register resets to all zeros.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
module mbpr_regs (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // register port
  input wire logic [mbpr_pkg::MBPR_AW-1:0] REG_ADDR,
  input wire logic [mbpr_pkg::MBPR_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [mbpr_pkg::MBPR_DW-1:0] REG_RDATA,
  output logic REG_RVALID,
  output logic REG_ADDR_HIT,
  // bias generator controls
  output mbpr_pkg::mbpr_bias_s BIAS_CTRL,
  // preamplifier routing switches
  output mbpr_pkg::mbpr_lpos_s LEFT_POS_SW,
  output mbpr_pkg::mbpr_lneg_s LEFT_NEG_SW,
  output mbpr_pkg::mbpr_rpos_s RIGHT_POS_SW
);
  import mbpr_pkg::*;

  // ==========================================================================
  // bus carrier
  mbpr_bus_s bus;
  assign bus = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

  // ==========================================================================
  // address decode
  wire logic hit_rsvd_a;
  wire logic hit_bias;
  wire logic hit_lpos;
  wire logic hit_rsvd_b;
  wire logic hit_lneg;
  wire logic hit_rpos;
  wire logic hit_rsvd_c;
  wire logic hit_any;
  assign hit_rsvd_a = (bus.addr >= RSVD_A_FIRST) &&
                      (bus.addr <= RSVD_A_LAST);
  assign hit_bias = (bus.addr == MIC_BIAS_CONFIG_OFS);
  assign hit_lpos = (bus.addr == LEFT_PREAMP_POS_OFS);
  assign hit_rsvd_b = (bus.addr == RSVD_B_OFS);
  assign hit_lneg = (bus.addr == LEFT_PREAMP_NEG_OFS);
  assign hit_rpos = (bus.addr == RIGHT_PREAMP_POS_OFS);
  assign hit_rsvd_c = (bus.addr == RSVD_C_OFS);
  assign hit_any = hit_rsvd_a | hit_bias | hit_lpos | hit_rsvd_b |
                   hit_lneg | hit_rpos | hit_rsvd_c;
  // combinational flag so software can probe which offsets exist
  assign REG_ADDR_HIT = hit_any;

  // ==========================================================================
  // write enables
  // reserved offsets have no storage, so writes there simply vanish
  wire logic we_bias;
  wire logic we_lpos;
  wire logic we_lneg;
  wire logic we_rpos;
  assign we_bias = CLK_EN & bus.wr & hit_bias;
  assign we_lpos = CLK_EN & bus.wr & hit_lpos;
  assign we_lneg = CLK_EN & bus.wr & hit_lneg;
  assign we_rpos = CLK_EN & bus.wr & hit_rpos;

  // ==========================================================================
  // storage and next values
  logic [7:0] bias_q;
  logic [7:0] lpos_q;
  logic [7:0] lneg_q;
  logic [7:0] rpos_q;
  wire logic [7:0] bias_d;
  wire logic [7:0] lpos_d;
  wire logic [7:0] lneg_d;
  wire logic [7:0] rpos_d;

  // only bits 6:3 of the bias register hold state, the rest stay zero
  assign bias_d = we_bias ? (bus.wdata & BIAS_WR_MASK) : bias_q;
  assign lpos_d = we_lpos ? bus.wdata : lpos_q;
  assign lneg_d = we_lneg ? bus.wdata : lneg_q;
  assign rpos_d = we_rpos ? bus.wdata : rpos_q;

  // bias register, all zero out of reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      bias_q <= BIAS_RESET;
    end else begin
      bias_q <= bias_d;
    end
  end

  // routing registers, every source disconnected out of reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      lpos_q <= ROUTE_RESET;
      lneg_q <= ROUTE_RESET;
      rpos_q <= ROUTE_RESET;
    end else begin
      lpos_q <= lpos_d;
      lneg_q <= lneg_d;
      rpos_q <= rpos_d;
    end
  end

  // ==========================================================================
  // read mux
  // reserved and unmapped offsets both answer zero
  wire logic [7:0] rd_mux;
  assign rd_mux = hit_bias ? (bias_q & BIAS_WR_MASK) :
                  hit_lpos ? lpos_q :
                  hit_lneg ? lneg_q :
                  hit_rpos ? rpos_q :
                  RSVD_RESET;

  // read data stands for the cycle after the strobe and is held while CLK_EN is low
  logic [7:0] rdata_q;
  logic rvalid_q;
  wire logic [7:0] rdata_d;
  wire logic rvalid_d;
  assign rvalid_d = CLK_EN ? bus.rd : rvalid_q;
  assign rdata_d = !CLK_EN ? rdata_q : bus.rd ? rd_mux : RSVD_RESET;

  // read answer register
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      rdata_q <= RSVD_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end
  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;

  // ==========================================================================
  // bias generator controls
  // power, level and source straight from flops; direct_to_supply is decoded from the level flops
  assign BIAS_CTRL.power_up = bias_q[BIAS_PWR_BIT];
  assign BIAS_CTRL.level = bias_q[BIAS_LVL_HI:BIAS_LVL_LO];
  assign BIAS_CTRL.from_regulator = bias_q[BIAS_SRC_BIT];
  assign BIAS_CTRL.direct_to_supply =
    (bias_q[BIAS_LVL_HI:BIAS_LVL_LO] == BIAS_TO_SUPPLY);

  // ==========================================================================
  // routing decode, one decoder per terminal
  wire logic [11:0] lpos_sw;
  wire logic [11:0] lneg_sw;
  wire logic [11:0] rpos_sw;

  mbpr_route_dec #(.FIELDS(4)) u_dec_lpos (
    .route(lpos_q),
    .sw(lpos_sw)
  );
  mbpr_route_dec #(.FIELDS(4)) u_dec_lneg (
    .route(lneg_q),
    .sw(lneg_sw)
  );
  mbpr_route_dec #(.FIELDS(4)) u_dec_rpos (
    .route(rpos_q),
    .sw(rpos_sw)
  );

  // field 3 (bits 7:6) lands in the top of each packed struct
  assign LEFT_POS_SW = mbpr_lpos_s'(lpos_sw);
  assign LEFT_NEG_SW = mbpr_lneg_s'(lneg_sw);
  assign RIGHT_POS_SW = mbpr_rpos_s'(rpos_sw);

endmodule

// [test/mbpr_regs_assertions.sv]
// checker for the bias and routing register bank
// assumes it is bound onto the ports of mbpr_regs
`timescale 1ns/1ps
module mbpr_regs_chk (
  // clock, reset, enable
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // register port
  input wire logic [mbpr_pkg::MBPR_AW-1:0] REG_ADDR,
  input wire logic [mbpr_pkg::MBPR_DW-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [mbpr_pkg::MBPR_DW-1:0] REG_RDATA,
  input wire logic REG_RVALID,
  // control outputs
  input wire mbpr_pkg::mbpr_bias_s BIAS_CTRL,
  input wire mbpr_pkg::mbpr_lpos_s LEFT_POS_SW,
  input wire mbpr_pkg::mbpr_lneg_s LEFT_NEG_SW,
  input wire mbpr_pkg::mbpr_rpos_s RIGHT_POS_SW
);
  import mbpr_pkg::*;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================
  // helpers
  logic [7:0] wd_q;
  // last write data, so field slices need no slice of $past
  always_ff @(posedge SYS_CLK) wd_q <= REG_WDATA;
  function automatic mbpr_sw_s dec(logic [1:0] c);
    return {c == 2'h1, c == 2'h2, c == 2'h3};
  endfunction
  sequence s_wr(logic [7:0] a);
    REG_WR && CLK_EN && REG_ADDR == a;
  endsequence
  sequence s_rd(logic [7:0] a);
    REG_RD && CLK_EN && REG_ADDR == a;
  endsequence
  // ==========================================================
  // properties
  a_read_answer: assert property (
    REG_RD && CLK_EN |=> REG_RVALID) else $error("read not answered");
  a_bias_mask: assert property (
    s_rd(8'h33) |=> REG_RDATA[7] == 1'b0 && REG_RDATA[2:0] == 3'h0)
    else $error("bias reserved bits read nonzero");
  a_rsvd_zero: assert property (
    REG_RD && CLK_EN && (REG_ADDR inside {[8'h1A:8'h32], 8'h35, 8'h38})
    |=> REG_RDATA == 8'h00) else $error("reserved byte read nonzero");
  a_bias_power: assert property (
    s_wr(8'h33) |=> BIAS_CTRL.power_up == wd_q[6])
    else $error("bias power bit wrong");
  a_bias_level: assert property (
    s_wr(8'h33) |=> BIAS_CTRL.level == wd_q[5:4] &&
    BIAS_CTRL.direct_to_supply == (wd_q[5:4] == 2'h3))
    else $error("bias level wrong");
  a_bias_source: assert property (
    s_wr(8'h33) |=> BIAS_CTRL.from_regulator == wd_q[3])
    else $error("bias source wrong");
  a_lpos_route: assert property (
    s_wr(8'h34) |=> LEFT_POS_SW.input_one_left == dec(wd_q[7:6]) &&
    LEFT_POS_SW.input_one_right == dec(wd_q[1:0]))
    else $error("left positive routing wrong");
  a_lneg_route: assert property (
    s_wr(8'h36) |=> LEFT_NEG_SW.left_first_common_tap == dec(wd_q[7:6]))
    else $error("left negative routing wrong");
  a_rpos_route: assert property (
    s_wr(8'h37) |=> RIGHT_POS_SW.input_two_left == dec(wd_q[1:0]))
    else $error("right positive routing wrong");
  // a reset edge may clear the outputs, so it must not start an attempt
  a_static_out: assert property (
    RST_B && !(REG_WR && CLK_EN) |=> $stable(BIAS_CTRL) &&
    $stable(LEFT_POS_SW)
    && $stable(LEFT_NEG_SW) && $stable(RIGHT_POS_SW))
    else $error("control output moved without write");
endmodule

// [test/tb_mbpr_regs.sv]
// self-checking bench for the bias and routing register bank
// assumes mbpr_pkg, mbpr_regs and the checker compiled before it
`timescale 1ns/1ps
module tb_mbpr_regs;
  import mbpr_pkg::*;
  logic clk = 0, rst_b = 0, en = 1, wr = 0, rd = 0, rvld, hit;
  logic [7:0] addr = 8'h00, wdat = 8'h00, rdat;
  logic [7:0] ofs[3] = '{8'h34, 8'h36, 8'h37};
  mbpr_bias_s bias;
  mbpr_lpos_s lpos;
  mbpr_lneg_s lneg;
  mbpr_rpos_s rpos;
  int mismatches = 0, tests_run = 0;
  always #2.5 clk = ~clk;
  mbpr_regs dut (.SYS_CLK(clk), .RST_B(rst_b), .CLK_EN(en),
    .REG_ADDR(addr), .REG_WDATA(wdat), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdat), .REG_RVALID(rvld), .REG_ADDR_HIT(hit),
    .BIAS_CTRL(bias), .LEFT_POS_SW(lpos), .LEFT_NEG_SW(lneg),
    .RIGHT_POS_SW(rpos));
  // ==========================================================
  // compare, bus and model helpers
  task automatic chk(string n, logic [11:0] e, logic [11:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  // data and valid are only looked at in the one cycle they stand
  task automatic rd_reg(logic [7:0] a, logic [7:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(n, {4'h1, e}, {3'h0, rvld, rdat});
  endtask
  // expected switch groups: field 7:6 lands in the top group
  function automatic logic [11:0] sw_of(logic [7:0] v);
    for (int i = 0; i < 4; i++) begin
      sw_of[3*i +: 3] = {v[2*i +: 2] == 2'h1, v[2*i +: 2] == 2'h2,
        v[2*i +: 2] == 2'h3};
    end
  endfunction
  function automatic logic [11:0] sw_at(logic [7:0] a);
    return a == 8'h34 ? 12'(lpos) : a == 8'h36 ? 12'(lneg) : 12'(rpos);
  endfunction
  // ==========================================================
  // scenarios
  task automatic t_zero();
    chk("bias", 12'h000, 12'(bias));
    foreach (ofs[i]) begin
      chk("switches", 12'h000, sw_at(ofs[i]));
      rd_reg(ofs[i], 8'h00, "route rd");
    end
    rd_reg(8'h33, 8'h00, "bias rd");
  endtask
  // reserved bias bits are only ever written with their zero default
  task automatic t_bias();
    logic [7:0] v;
    for (int c = 0; c < 4; c++) begin
      v = {1'b0, c[0], 2'(c), c[1], 3'h0};
      wr_reg(8'h33, v);
      chk("bias", {7'h00, c[0], 2'(c), c[1], c == 3}, 12'(bias));
      rd_reg(8'h33, v & 8'h78, "bias rd");
    end
  endtask
  // fields get distinct codes so a swapped field shows
  task automatic t_route();
    logic [7:0] v;
    foreach (ofs[i]) begin
      for (int c = 0; c < 4; c++) begin
        v = {2'(c), 2'(c + 1), 2'(c + 2), 2'(c + 3)};
        wr_reg(ofs[i], v);
        chk("switches", sw_of(v), sw_at(ofs[i]));
        rd_reg(ofs[i], v, "route rd");
      end
    end
  endtask
  task automatic t_rsvd();
    logic [7:0] bad[7] = '{8'h1A, 8'h26, 8'h32, 8'h35, 8'h38, 8'h19, 8'h39};
    foreach (bad[i]) wr_reg(bad[i], 8'hFF);
    // the first five offsets exist, the last two lie outside the bank
    foreach (bad[i]) begin
      rd_reg(bad[i], 8'h00, "reserved rd");
      chk("addr hit", 12'(i < 5), 12'(hit));
    end
    foreach (ofs[i]) chk("kept", sw_of(8'hC6), sw_at(ofs[i]));
  endtask
  // enable moves only on a rising edge, like every other bus input
  task automatic t_hold();
    @(posedge clk) en <= 1'b0;
    wr_reg(8'h34, 8'h55);
    @(posedge clk) en <= 1'b1;
    #1;
    chk("frozen", sw_of(8'hC6), 12'(lpos));
    rd_reg(8'h33, 8'h78, "bias rd");
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // main sequence, with a second reset in mid-run
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    t_zero();
    t_bias();
    t_route();
    t_rsvd();
    t_hold();
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    #1;
    t_zero();
    give_verdict();
  end
  // a hang counts against the run
  initial begin
    #50000;
    mismatches++;
    give_verdict();
  end
endmodule
bind mbpr_regs mbpr_regs_chk u_chk (.SYS_CLK, .RST_B, .CLK_EN, .REG_ADDR,
  .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_RVALID, .BIAS_CTRL,
  .LEFT_POS_SW, .LEFT_NEG_SW, .RIGHT_POS_SW);
